// >>> design/watchdog_pkg.sv
package watchdog_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] CTRL_INDEX = 8'h21;
  localparam logic [7:0] CAUSE_INDEX = 8'h22;

  // Field positions of watchdog_control.
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned IE_BIT = 6;
  localparam int unsigned P3_BIT = 5;
  localparam int unsigned UNLOCK_BIT = 4;
  localparam int unsigned EN_BIT = 3;
  localparam int unsigned PLO_MSB = 2;

  // Field positions of reset_cause_register.
  localparam int unsigned POR_BIT = 0;
  localparam int unsigned DOG_BIT = 3;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [23:0] UPPER_ZERO = 24'h000000;

  // Protected-change window, in system clock cycles.
  localparam int unsigned UNLOCK_W = 3;
  localparam logic [UNLOCK_W-1:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [UNLOCK_W-1:0] UNLOCK_ONE = 3'h1;
  localparam logic [UNLOCK_W-1:0] UNLOCK_IDLE = 3'h0;

  // Period codes above this one are reserved.
  localparam logic [3:0] PERIOD_MAX_CODE = 4'h9;
  localparam logic [3:0] PERIOD_RESET = 4'h0;
  localparam int unsigned BASE_OSC_CYCLES = 2048;

  // Rates; the system clock must be well above the oscillator to sample it.
  localparam int unsigned OSC_FREQ_KHZ = 128;
  localparam int unsigned SYS_FREQ_KHZ = 200000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Action taken on a time-out, from enable and interrupt enable.
  typedef enum logic [1:0] {
    ACT_STOPPED,
    ACT_IRQ,
    ACT_RESET,
    ACT_IRQ_FIRST
  } action_t;

endpackage : watchdog_pkg

// >>> design/watchdog_counter.sv
`timescale 1ns/1ps
`default_nettype none

module watchdog_counter #(
  parameter int unsigned BASE_CYCLES = watchdog_pkg::BASE_OSC_CYCLES,
  parameter int unsigned CNT_W = 21
) (
  input wire logic aclk,              // System clock.
  input wire logic aresetn,           // Synchronous reset, active low.
  input wire logic osc_rise,          // One oscillator edge, already synchronised.
  input wire logic restart,           // Clear the count.
  input wire logic run,               // Counting allowed.
  input wire logic [3:0] period_code, // Period select code.
  output logic timeout                // One-cycle time-out pulse.
);

  if (BASE_CYCLES < 1 || (64'(BASE_CYCLES) << 9) > (64'h1 << CNT_W)) begin : g_check
    $error("watchdog_counter: CNT_W too small for BASE_CYCLES");
  end

  logic [CNT_W-1:0] count;

  // Reserved codes fall back to the longest valid period.
  function automatic logic [CNT_W-1:0] last_count(input logic [3:0] code);
    logic [3:0] eff;
    eff = (code > watchdog_pkg::PERIOD_MAX_CODE) ? watchdog_pkg::PERIOD_MAX_CODE : code; // R16 R21
    return CNT_W'((64'(BASE_CYCLES) << eff) - 64'h1); // R15
  endfunction : last_count

  // A shortened period may leave the count past its end; that expires on the next oscillator edge.
  always_ff @(posedge aclk) begin
    if (!aresetn || restart || !run) begin
      count <= '0;
      timeout <= 1'b0;
    end else if (osc_rise) begin
      if (count >= last_count(period_code)) begin // R15
        count <= '0;
        timeout <= 1'b1;
      end else begin
        count <= count + 1'b1;
        timeout <= 1'b0;
      end
    end else begin
      timeout <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_timeout_at_end;
    timeout |-> $past(osc_rise) && $past(count) >= $past(last_count(period_code)) && $past(run);
  endproperty
  a_timeout_at_end: assert property (p_timeout_at_end) else $error("time-out before period end"); // R15

  property p_reserved_code;
    period_code > watchdog_pkg::PERIOD_MAX_CODE |->
      last_count(period_code) == CNT_W'((64'(BASE_CYCLES) << watchdog_pkg::PERIOD_MAX_CODE) - 64'h1);
  endproperty
  a_reserved_code: assert property (p_reserved_code) else $error("reserved code not mapped"); // R16 R21

endmodule : watchdog_counter

`default_nettype wire

// >>> design/watchdog_timer_reset_flags.sv
// How it works
// (R1) Power-on reset sets the power-on cause flag; only writing zero clears it.
// (R2) Software should read then clear the reset cause register early after start-up.
// (R3) Eight-bit control register at index 0x21 with flag, enables, unlock and period.
// (R4) Time-out in interrupt mode sets the flag; vector or write-one clears it.
// (R5) Interrupt requested only with global enable, interrupt enable and pending flag.
// (R6) With both enables set, time-out interrupts and clears interrupt enable.
// (R7) Enables decode to stopped, interrupt, reset, or interrupt then reset.
// (R8) Change unlock clears itself four system clock cycles after being written.
// (R9) Writing enable to zero is accepted only while change unlock reads one.
// (R10) Period changes need change unlock when the protected sequence applies.
// (R11) Software unlocks with unlock and enable both one, then writes within four cycles.
// (R12) At safety level two the watchdog can never be disabled.
// (R13) At safety level one the dog-reset cause flag forces enable to one.
// (R14) Unused watchdog: start-up code clears the dog flag then disables.
// (R15) Period is 2048 times two to the code oscillator cycles.
// (R16) Reserved period codes use a valid setting instead.
// (R17) Counter advances on the 128 kHz oscillator, not the system clock.
// (R18) Count restarts on restart instruction, when disabled, and on chip reset.
// (R19) Reset-mode time-out gives a one-cycle system reset and sets the dog flag.
// (R20) Fuse selects level: one starts disabled with free period, two starts enabled.
// (R21) Reserved codes map to 1001; oscillator events are synchronised first.
// (R22) After reset enable reads its forced value; other control bits are zero.
`timescale 1ns/1ps
`default_nettype none

module watchdog_timer_reset_flags #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned BASE_CYCLES = watchdog_pkg::BASE_OSC_CYCLES
) (
  input wire logic aclk,                 // System clock, 200 MHz.
  input wire logic aresetn,              // Power-on reset, synchronous, active low.
  input wire logic osc_clk_in,           // 128 kHz watchdog oscillator, asynchronous.
  input wire logic safety_level_fuse,    // High selects safety level two.
  input wire logic global_irq_enable,    // Global interrupt enable of the core status register.
  input wire logic dog_restart,          // Restart instruction, one-cycle pulse.
  input wire logic vector_taken,         // Watchdog interrupt vector executing, pulse.
  input wire logic chip_reset,           // Any other chip reset, pulse or level.
  input wire logic awvalid,              // Write address valid.
  output logic awready,                  // Write address ready.
  input wire logic [ADDR_W-1:0] awaddr,  // Write byte address.
  input wire logic [2:0] awprot,         // Write protection, ignored.
  input wire logic wvalid,               // Write data valid.
  output logic wready,                   // Write data ready.
  input wire logic [31:0] wdata,         // Write data.
  input wire logic [3:0] wstrb,          // Write byte strobes.
  output logic bvalid,                   // Write response valid.
  input wire logic bready,               // Write response ready.
  output logic [1:0] bresp,              // Write response.
  input wire logic arvalid,              // Read address valid.
  output logic arready,                  // Read address ready.
  input wire logic [ADDR_W-1:0] araddr,  // Read byte address.
  input wire logic [2:0] arprot,         // Read protection, ignored.
  output logic rvalid,                   // Read data valid.
  input wire logic rready,               // Read data ready.
  output logic [31:0] rdata,             // Read data.
  output logic [1:0] rresp,              // Read response.
  output logic irq_request,              // Watchdog interrupt request, level.
  output logic system_reset              // System reset pulse, one cycle.
);

  if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_check
    $error("watchdog_timer_reset_flags: ADDR_W must be 10 to 32");
  end
  if (watchdog_pkg::SYS_FREQ_KHZ < 4 * watchdog_pkg::OSC_FREQ_KHZ) begin : g_rate_check
    $error("watchdog_timer_reset_flags: system clock too slow to sample the oscillator");
  end

  // Oscillator and fuse synchronisers; the first stages feed only the second.
  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  logic fuse_meta;
  logic level2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= osc_clk_in; // R17 R21
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fuse_meta <= 1'b0;
      level2 <= 1'b0;
    end else begin
      fuse_meta <= safety_level_fuse; // R20
      level2 <= fuse_meta;
    end
  end

  logic osc_rise;
  assign osc_rise = osc_sync && !osc_prev; // R17 R21

  // Control and cause state.
  logic timeout_flag;
  logic timeout_irq_enable;
  logic watchdog_enable;
  logic [3:0] period_select;
  logic [watchdog_pkg::UNLOCK_W-1:0] unlock_count;
  logic power_on_cause_flag;
  logic dog_reset_cause_flag;

  logic change_unlock;
  logic enable_eff;
  logic internal_reset;
  logic timeout;
  logic run;
  watchdog_pkg::action_t action;

  function automatic watchdog_pkg::action_t decode_action(input logic en, input logic ie);
    case ({en, ie})
      2'b00: return watchdog_pkg::ACT_STOPPED; // R7
      2'b01: return watchdog_pkg::ACT_IRQ;
      2'b10: return watchdog_pkg::ACT_RESET;
      2'b11: return watchdog_pkg::ACT_IRQ_FIRST;
      default: return watchdog_pkg::ACT_STOPPED;
    endcase
  endfunction : decode_action

  function automatic logic addr_hits(input logic [ADDR_W-1:0] addr, input logic [7:0] index);
    return addr[ADDR_W-1:2] == (ADDR_W-2)'(index);
  endfunction : addr_hits

  assign change_unlock = unlock_count != watchdog_pkg::UNLOCK_IDLE;
  // Level two always enables; at level one the dog flag forces the enable on.
  assign enable_eff = watchdog_enable || level2 || dog_reset_cause_flag; // R12 R13 R20 R22
  assign internal_reset = chip_reset || system_reset;
  assign action = decode_action(enable_eff, timeout_irq_enable); // R7
  assign run = action != watchdog_pkg::ACT_STOPPED;

  watchdog_counter #(
    .BASE_CYCLES(BASE_CYCLES),
    .CNT_W(21)
  ) u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_rise(osc_rise),
    .restart(dog_restart || internal_reset), // R18
    .run(run), // R18
    .period_code(period_select),
    .timeout(timeout)
  );

  // Write channel capture; address and data may arrive in either order.
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] wd;
  logic wstrb0_q;
  logic do_write;
  logic wr_ctrl;
  logic wr_cause;
  logic unlock_start;

  assign do_write = !awready && !wready && !bvalid;
  assign wr_ctrl = do_write && wstrb0_q && addr_hits(aw_addr_q, watchdog_pkg::CTRL_INDEX); // R3
  assign wr_cause = do_write && wstrb0_q && addr_hits(aw_addr_q, watchdog_pkg::CAUSE_INDEX);
  assign unlock_start = wr_ctrl && wd[watchdog_pkg::UNLOCK_BIT] && wd[watchdog_pkg::EN_BIT]; // R11

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= watchdog_pkg::RESP_OKAY;
      aw_addr_q <= '0;
      wd <= watchdog_pkg::BYTE_ZERO;
      wstrb0_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wd <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= (addr_hits(aw_addr_q, watchdog_pkg::CTRL_INDEX) || addr_hits(aw_addr_q, watchdog_pkg::CAUSE_INDEX))
                 ? watchdog_pkg::RESP_OKAY : watchdog_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read channel; one request at a time, data one cycle after the address.
  logic [7:0] ctrl_read;
  logic [7:0] cause_read;

  always_comb begin
    ctrl_read = watchdog_pkg::BYTE_ZERO;
    ctrl_read[watchdog_pkg::FLAG_BIT] = timeout_flag; // R3
    ctrl_read[watchdog_pkg::IE_BIT] = timeout_irq_enable;
    ctrl_read[watchdog_pkg::P3_BIT] = period_select[3];
    ctrl_read[watchdog_pkg::UNLOCK_BIT] = change_unlock;
    ctrl_read[watchdog_pkg::EN_BIT] = enable_eff;
    ctrl_read[watchdog_pkg::PLO_MSB:0] = period_select[2:0];
    cause_read = watchdog_pkg::BYTE_ZERO;
    cause_read[watchdog_pkg::POR_BIT] = power_on_cause_flag;
    cause_read[watchdog_pkg::DOG_BIT] = dog_reset_cause_flag;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= watchdog_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      if (addr_hits(araddr, watchdog_pkg::CTRL_INDEX)) begin
        rdata <= {watchdog_pkg::UPPER_ZERO, ctrl_read};
        rresp <= watchdog_pkg::RESP_OKAY;
      end else if (addr_hits(araddr, watchdog_pkg::CAUSE_INDEX)) begin
        rdata <= {watchdog_pkg::UPPER_ZERO, cause_read};
        rresp <= watchdog_pkg::RESP_OKAY;
      end else begin
        rdata <= '0;
        rresp <= watchdog_pkg::RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  logic irq_timeout;
  logic reset_timeout;
  logic ie_clear_due;
  assign irq_timeout = timeout && (action == watchdog_pkg::ACT_IRQ || action == watchdog_pkg::ACT_IRQ_FIRST);
  assign reset_timeout = timeout && action == watchdog_pkg::ACT_RESET;

  // Enable, interrupt enable and period. A software write of the interrupt enable wins over the hardware
  // clear, so a re-arm is never lost; the clear lags one cycle so the request still sees it.
  always_ff @(posedge aclk) begin
    if (!aresetn || internal_reset) begin
      timeout_irq_enable <= 1'b0; // R22
      watchdog_enable <= 1'b0;
      period_select <= watchdog_pkg::PERIOD_RESET;
      ie_clear_due <= 1'b0;
    end else begin
      ie_clear_due <= timeout && action == watchdog_pkg::ACT_IRQ_FIRST && !wr_ctrl; // R6
      if (wr_ctrl) begin
        timeout_irq_enable <= wd[watchdog_pkg::IE_BIT];
      end else if (ie_clear_due) begin
        timeout_irq_enable <= 1'b0; // R6
      end
      if (wr_ctrl && wd[watchdog_pkg::EN_BIT]) begin
        watchdog_enable <= 1'b1;
      end else if (wr_ctrl && change_unlock && !level2) begin
        watchdog_enable <= 1'b0; // R9 R12
      end
      if (wr_ctrl && (!level2 || change_unlock)) begin
        period_select <= {wd[watchdog_pkg::P3_BIT], wd[watchdog_pkg::PLO_MSB:0]}; // R10 R20
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || internal_reset) begin
      unlock_count <= watchdog_pkg::UNLOCK_IDLE;
    end else if (unlock_start) begin
      unlock_count <= watchdog_pkg::UNLOCK_CYCLES; // R8
    end else if (change_unlock) begin
      unlock_count <= unlock_count - watchdog_pkg::UNLOCK_ONE; // R8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || internal_reset) begin
      timeout_flag <= 1'b0;
    end else if (irq_timeout) begin
      timeout_flag <= 1'b1; // R4
    end else if (vector_taken || (wr_ctrl && wd[watchdog_pkg::FLAG_BIT])) begin
      timeout_flag <= 1'b0; // R4
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_reset <= 1'b0;
    end else begin
      system_reset <= reset_timeout && !system_reset; // R19
    end
  end

  // Cause flags survive chip resets; only the power-on reset reinitialises them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_on_cause_flag <= 1'b1; // R1
      dog_reset_cause_flag <= 1'b0;
    end else begin
      if (wr_cause && !wd[watchdog_pkg::POR_BIT]) begin
        power_on_cause_flag <= 1'b0; // R1
      end
      if (reset_timeout) begin
        dog_reset_cause_flag <= 1'b1; // R19
      end else if (wr_cause && !wd[watchdog_pkg::DOG_BIT]) begin
        dog_reset_cause_flag <= 1'b0; // R13
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || internal_reset) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= global_irq_enable && timeout_irq_enable && timeout_flag; // R5
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_por_sticky;
    power_on_cause_flag && !(wr_cause && !wd[watchdog_pkg::POR_BIT]) |=> power_on_cause_flag;
  endproperty
  a_por_sticky: assert property (p_por_sticky) else $error("power-on flag lost"); // R1

  property p_flag_set;
    irq_timeout && !internal_reset |=> timeout_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("time-out flag not set"); // R4

  property p_irq_cause;
    irq_request |-> $past(global_irq_enable) && $past(timeout_irq_enable) && $past(timeout_flag);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause"); // R5

  property p_ie_cleared;
    timeout && action == watchdog_pkg::ACT_IRQ_FIRST && !wr_ctrl ##1 !wr_ctrl |=> !timeout_irq_enable;
  endproperty
  a_ie_cleared: assert property (p_ie_cleared) else $error("interrupt enable not cleared"); // R6

  property p_unlock_open;
    unlock_start && !internal_reset |=> change_unlock [*4];
  endproperty
  a_unlock_open: assert property (p_unlock_open) else $error("unlock window short"); // R8

  property p_unlock_close;
    unlock_count == watchdog_pkg::UNLOCK_ONE && !unlock_start |=> !change_unlock;
  endproperty
  a_unlock_close: assert property (p_unlock_close) else $error("unlock window long"); // R8

  property p_disable_refused;
    wr_ctrl && !change_unlock && watchdog_enable && !internal_reset |=> watchdog_enable;
  endproperty
  a_disable_refused: assert property (p_disable_refused) else $error("locked disable taken"); // R9

  property p_level2_runs;
    level2 && $past(level2) |-> run;
  endproperty
  a_level2_runs: assert property (p_level2_runs) else $error("level two stopped"); // R12

  property p_dog_forces;
    dog_reset_cause_flag |-> ctrl_read[watchdog_pkg::EN_BIT];
  endproperty
  a_dog_forces: assert property (p_dog_forces) else $error("enable not forced"); // R13

  property p_reset_pulse;
    reset_timeout && !system_reset |=> system_reset && dog_reset_cause_flag ##1 !system_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("bad system reset pulse"); // R19

endmodule : watchdog_timer_reset_flags

`default_nettype wire

// >>> test/watchdog_timer_reset_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %0h seen %0h", n, e, s); end end

module watchdog_timer_reset_flags_tb;
  localparam logic [11:0] A_CTRL = {2'b00, watchdog_pkg::CTRL_INDEX, 2'b00};
  localparam logic [11:0] A_CAUSE = {2'b00, watchdog_pkg::CAUSE_INDEX, 2'b00};
  localparam logic [11:0] A_NONE = 12'h100;
  localparam logic [1:0] OK = watchdog_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = watchdog_pkg::RESP_SLVERR;
  logic aclk = 1'b0, aresetn = 1'b0, osc_clk_in = 1'b0, fuse = 1'b0, gie = 1'b0;
  logic dog_restart = 1'b0, vector_taken = 1'b0, chip_reset = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, seed = 32'h00000059;
  logic awready, wready, bvalid, arready, rvalid, irq_request, system_reset;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [1:0] eb;
  logic [33:0] er;
  logic [3:0] p;
  logic [7:0] v;
  int fail_count = 0, num_checks = 0, cyc = 0, ticks = 0;

  // A base of four oscillator ticks keeps the periods used here, codes 0 to 2, short enough to watch in full.
  watchdog_timer_reset_flags #(.ADDR_W(12), .BASE_CYCLES(4)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .osc_clk_in(osc_clk_in), .safety_level_fuse(fuse),
    .global_irq_enable(gie), .dog_restart(dog_restart), .vector_taken(vector_taken),
    .chip_reset(chip_reset), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .irq_request(irq_request), .system_reset(system_reset));

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  // The oscillator is sped up and started off phase so it never lines up with aclk.
  initial begin
    #37;
    forever #200 osc_clk_in = ~osc_clk_in;
  end

  always @(posedge osc_clk_in) ticks++;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // Ready is raised only after the request is taken, so back-to-back calls never drive one signal twice.
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    rq.push_back({r, 24'h000000, d});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  task automatic kick();
    dog_restart <= 1'b1;
    ticks = 0;
    @(posedge aclk);
    dog_restart <= 1'b0;
  endtask : kick

  task automatic wait_hi(input logic is_rst);
    for (int i = 0; i < 4000; i++) begin
      @(posedge aclk);
      if ((is_rst ? system_reset : irq_request) === 1'b1)
        break;
    end
  endtask : wait_hi

  task automatic tend(input string name);
    $display("test %s finished", name);
  endtask : tend

  always @(posedge aclk) begin
    cyc++;
    if (bvalid === 1'b1 && bready) begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (rvalid === 1'b1 && rready) begin
      er = rq.pop_front();
      `CHK("read", er, {rresp, rdata})
    end
    if (cyc == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_CTRL, 8'h00, OK);
    rd(A_CAUSE, 8'h01, OK);
    rd(A_NONE, 8'h00, ERR);
    wr(A_NONE, 8'hFF, ERR);
    wr(A_CAUSE, 8'hFF, OK);
    rd(A_CAUSE, 8'h01, OK);
    wr(A_CAUSE, 8'h00, OK);
    rd(A_CAUSE, 8'h00, OK);
    tend("reset values");
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 4'hC : 4'(xs());
      v = {2'b00, p[3], 2'b00, p[2:0]};
      wr(A_CTRL, v, OK);
      rd(A_CTRL, v, OK);
    end
    tend("free period");
    wr(A_CTRL, 8'h40, OK);
    kick();
    repeat (700) @(posedge aclk);
    `CHK("irq masked", 1'b0, irq_request)
    rd(A_CTRL, 8'hC0, OK);
    gie <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("irq", 1'b1, irq_request)
    vector_taken <= 1'b1;
    @(posedge aclk);
    vector_taken <= 1'b0;
    rd(A_CTRL, 8'h40, OK);
    `CHK("irq off", 1'b0, irq_request)
    for (int c = 0; c < 3; c++) begin
      wr(A_CTRL, 8'h40 | 8'(c), OK);
      kick();
      wait_hi(1'b0);
      `CHK("period", 1'b1, ticks >= (4 << c) - 1 && ticks <= (4 << c) + 1)
      wr(A_CTRL, 8'hC0 | 8'(c), OK);
      rd(A_CTRL, 8'h40 | 8'(c), OK);
    end
    tend("interrupt mode");
    wr(A_CTRL, 8'h42, OK);
    chip_reset <= 1'b1;
    @(posedge aclk);
    chip_reset <= 1'b0;
    rd(A_CTRL, 8'h00, OK);
    wr(A_CTRL, 8'h48, OK);
    kick();
    wait_hi(1'b0);
    `CHK("irq first", 1'b1, irq_request)
    rd(A_CTRL, 8'h88, OK);
    wait_hi(1'b1);
    `CHK("reset", 1'b1, system_reset)
    #1;
    `CHK("reset pulse", 1'b0, system_reset)
    rd(A_CAUSE, 8'h08, OK);
    rd(A_CTRL, 8'h08, OK);
    kick();
    wr(A_CTRL, 8'h18, OK);
    wr(A_CTRL, 8'h00, OK);
    rd(A_CTRL, 8'h08, OK);
    wr(A_CAUSE, 8'h00, OK);
    rd(A_CTRL, 8'h00, OK);
    wr(A_CTRL, 8'h08, OK);
    wr(A_CTRL, 8'h00, OK);
    rd(A_CTRL, 8'h08, OK);
    wr(A_CTRL, 8'h18, OK);
    wr(A_CTRL, 8'h00, OK);
    rd(A_CTRL, 8'h00, OK);
    wr(A_CTRL, 8'h18, OK);
    repeat (8) @(posedge aclk);
    wr(A_CTRL, 8'h00, OK);
    rd(A_CTRL, 8'h08, OK);
    tend("reset and unlock");
    fuse <= 1'b1;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(A_CTRL, 8'h08, OK);
    rd(A_CAUSE, 8'h01, OK);
    wr(A_CTRL, 8'h0A, OK);
    rd(A_CTRL, 8'h08, OK);
    wr(A_CTRL, 8'h18, OK);
    wr(A_CTRL, 8'h00, OK);
    rd(A_CTRL, 8'h08, OK);
    wr(A_CTRL, 8'h18, OK);
    wr(A_CTRL, 8'h0A, OK);
    rd(A_CTRL, 8'h0A, OK);
    wait_hi(1'b1);
    `CHK("level two reset", 1'b1, system_reset)
    tend("safety level two");
    tally_and_finish();
  end
endmodule : watchdog_timer_reset_flags_tb
`default_nettype wire
